// ### dv/sfr_link_props.sv
// assertions on the link between controller and flash ends
`default_nettype none
module sfr_link_props (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic so_oe_i
);
    int unsigned low_cnt;
    int unsigned hi_cnt;
    // high count resets to its saturated value so power-up selects are not held to the reset gap
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt <= 0;
            hi_cnt <= 2000;
        end else begin
            low_cnt <= reset_n_i ? 0 : low_cnt + 1;
            hi_cnt <= !reset_n_i ? 0 : (hi_cnt >= 2000 ? 2000 : hi_cnt + 1);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rst_width;
        $rose(reset_n_i) |-> low_cnt inside {[2000:2001]};
    endproperty
    a_rst_width: assert property (p_rst_width) else $error("reset width");
    property p_cs_in_rst;
        !reset_n_i |-> cs_n_i;
    endproperty
    a_cs_in_rst: assert property (p_cs_in_rst) else $error("select in reset");
    property p_sel_gap;
        $fell(cs_n_i) |-> hi_cnt >= 2000;
    endproperty
    a_sel_gap: assert property (p_sel_gap) else $error("select too soon");
    property p_so_rel;
        !reset_n_i [*4] |-> !so_oe_i;
    endproperty
    a_so_rel: assert property (p_so_rel) else $error("output driven in reset");
    property p_oe_sel;
        $rose(so_oe_i) |-> !cs_n_i && reset_n_i;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("output unselected");
    property p_rec_hold;
        $rose(reset_n_i) |-> cs_n_i [*8];
    endproperty
    a_rec_hold: assert property (p_rec_hold) else $error("select in recovery");
    property p_sclk_frame;
        $rose(sclk_i) |-> !cs_n_i;
    endproperty
    a_sclk_frame: assert property (p_sclk_frame) else $error("clock outside frame");
    // an aborted frame may cut the high phase short
    property p_sclk_high;
        disable iff (!rstn_i || !reset_n_i) $rose(sclk_i) |-> sclk_i [*8] ##1 !sclk_i;
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("clock high time");
endmodule // sfr_link_props
`default_nettype wire

// ### dv/tb.sv
// bench joining controller and flash ends across the link
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] OPS [5] = '{8'h02, 8'h20, 8'hd8, 8'h60, 8'h01};
    localparam int REC [5] = '{2300, 2400, 2450, 2500, 2200};
    localparam logic [7:0] PICK [6] = '{8'h06, 8'h04, 8'hb7, 8'he9, 8'h7e, 8'h98};
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsup = 1'b0;
    logic dsup = 1'b0;
    logic rst_req = 1'b0;
    logic cv = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic cmd_rdy, rdy, rsting, sv, standby, addr4, lock, in_rst, abort;
    logic write_enable_latch;
    logic write_in_progress;
    logic [7:0] st;
    logic [7:0] m_st = 8'h00;
    int mismatches = 0;
    int samples_checked = 0;
    sfr_link_if link ();
    sfr_flash_dev i_sfr_flash_dev (.clk_i(clk_i), .rstn_i(rstn_i), .link(link),
        .supply_ok_i(dsup), .standby_o(standby), .write_enable_latch_o(write_enable_latch),
        .write_in_progress_o(write_in_progress), .addr4_o(addr4),
        .lock_o(lock), .in_reset_o(in_rst), .op_aborted_o(abort));
    // settle and decode/read recovery run at their real lengths
    sfr_flash_host #(.REC_PROGRAM_CYC(2300), .REC_SMALL_CYC(2400), .REC_BLOCK_CYC(2450),
        .REC_CHIP_CYC(2500), .REC_STATUS_CYC(2200)) i_sfr_flash_host (.clk_i(clk_i),
        .rstn_i(rstn_i), .link(link), .supply_valid_i(hsup), .reset_req_i(rst_req),
        .cmd_valid_i(cv), .cmd_i(cmd), .cmd_ready_o(cmd_rdy), .ready_o(rdy),
        .resetting_o(rsting), .status_o(st), .status_valid_o(sv));
    sfr_link_props i_sfr_link_props (.clk_i(clk_i), .rstn_i(rstn_i), .reset_n_i(link.reset_n),
        .cs_n_i(link.cs_n), .sclk_i(link.sclk), .so_oe_i(link.so_oe));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_rdy(output int n);
        n = 0;
        while (rdy !== 1'b1 && n < 12000) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    // cut > 0 leaves the frame running so a reset can land mid-shift
    task automatic send(input logic [7:0] b, input int cut);
        int n;
        n = 0;
        while (cmd_rdy !== 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        cv <= 1'b1;
        cmd <= b;
        @(posedge clk_i);
        cv <= 1'b0;
        if (cut > 0) begin
            repeat (cut) @(posedge clk_i);
            return;
        end
        case (b)
            8'h06: m_st[1] = 1'b1;
            8'h04: m_st[1] = 1'b0;
            8'hb7, 8'he9: m_st[5] = (b == 8'hb7);
            8'h7e, 8'h98: m_st[6] = (b == 8'h7e);
            8'h02, 8'h20, 8'hd8, 8'h60, 8'h01: if (m_st[1]) m_st[1:0] = 2'b01;
            8'h05: begin
                while (sv !== 1'b1 && n < 9000) begin
                    @(negedge clk_i);
                    n++;
                end
                check(st, m_st, "status");
            end
        endcase
        @(negedge clk_i);
        wait_rdy(n);
    endtask
    task automatic do_reset(input int rec, input logic ab);
        int n;
        @(posedge clk_i);
        rst_req <= 1'b1;
        @(posedge clk_i);
        rst_req <= 1'b0;
        repeat (100) @(negedge clk_i);
        check({link.reset_n, link.cs_n, link.so_oe, in_rst, rsting}, 8'h0b, "in reset");
        wait_rdy(n);
        check((n + 100) inside {[1998 + rec:2006 + rec]}, 1'b1, "recovery");
        m_st = 8'h00;
        check({standby, write_in_progress, abort}, {2'b10, ab}, "after reset");
        check({write_enable_latch, addr4, lock}, 8'h00, "volatile reset");
        send(8'h05, 0);
    endtask
    initial begin
        logic [7:0] b;
        int n;
        void'($urandom(32'h209e43f5));
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (40) @(negedge clk_i);
        check({link.cs_n, cmd_rdy, standby}, 8'h04, "power-up hold");
        @(posedge clk_i);
        hsup <= 1'b1;
        // two sync stages plus the settle count before the first command
        wait_rdy(n);
        check((n >= 1000) && (n <= 1006), 1'b1, "settle delay");
        // device unpowered: the pull-up answers every status bit
        m_st = 8'hff;
        send(8'h06, 0);
        send(8'h05, 0);
        check(write_enable_latch, 1'b0, "latch unpowered");
        @(posedge clk_i);
        dsup <= 1'b1;
        m_st = 8'h00;
        repeat (10) @(negedge clk_i);
        check({standby, write_enable_latch}, 8'h02, "power-on state");
        $display("test power-up done");
        repeat (8) begin
            b = PICK[$urandom_range(5)];
            send(b, 0);
            check({write_enable_latch, lock, addr4}, {m_st[1], m_st[6:5]}, "volatile bits");
        end
        send(8'h05, 0);
        do_reset(2000, 1'b0);
        $display("test idle reset done");
        send(8'h05, 20);
        do_reset(8000, 1'b0);
        $display("test decode reset done");
        foreach (OPS[i]) begin
            send(8'h06, 0);
            send(OPS[i], 0);
            check({write_enable_latch, write_in_progress}, 8'h01, "op running");
            do_reset(REC[i], 1'b1);
        end
        $display("test operation reset done");
        finish_test();
    end
    // tests need about 42000 cycles; far beyond that means a hang
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        finish_test();
    end
endmodule // tb
`default_nettype wire

// ### hdl/sfr_cfg.svh
// constants for the serial flash reset and power-on link
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
`define SFR_CLK_PERIOD_NS 5
`define SFR_US2CYC(t) ((((t) * 1000) + `SFR_CLK_PERIOD_NS - 1) / `SFR_CLK_PERIOD_NS)
`define SFR_MS2CYC(t) `SFR_US2CYC((t) * 1000)
`define SFR_RESET_PULSE_MIN_US 10
`define SFR_RESET_TO_SELECT_US 10
`define SFR_RECOVERY_DECODE_US 40
`define SFR_RECOVERY_READ_US 40
`define SFR_RECOVERY_PROGRAM_US 310
`define SFR_RECOVERY_SMALL_ERASE_MS 12
`define SFR_RECOVERY_BLOCK_ERASE_MS 25
`define SFR_RECOVERY_CHIP_ERASE_MS 1000
`define SFR_RECOVERY_STATUS_WRITE_MS 40
`define SFR_RESET_PULSE_CYC `SFR_US2CYC(`SFR_RESET_PULSE_MIN_US)
`define SFR_RESET_TO_SELECT_CYC `SFR_US2CYC(`SFR_RESET_TO_SELECT_US)
`define SFR_SCLK_HALF 4'h8
`define SFR_CMD_WRITE_ENABLE 8'h06
`define SFR_CMD_WRITE_DISABLE 8'h04
`define SFR_CMD_READ_STATUS 8'h05
`define SFR_CMD_PROGRAM 8'h02
`define SFR_CMD_SMALL_SECTOR_ERASE 8'h20
`define SFR_CMD_BLOCK_ERASE 8'hd8
`define SFR_CMD_CHIP_ERASE 8'h60
`define SFR_CMD_STATUS_WRITE 8'h01
`define SFR_CMD_ENTER_ADDR4 8'hb7
`define SFR_CMD_EXIT_ADDR4 8'he9
`define SFR_CMD_LOCK_ALL 8'h7e
`define SFR_CMD_UNLOCK_ALL 8'h98
`define SFR_ST_WRITE_IN_PROGRESS 0
`define SFR_ST_WRITE_ENABLE_LATCH 1
`define SFR_ST_ADDR4 5
`define SFR_ST_LOCK 6
`endif

// ### hdl/sfr_flash_dev.sv
// flash device end: reset pin, power-on hold and minimal command decode
`include "sfr_cfg.svh"
`default_nettype none
module sfr_flash_dev #(
    // long enough that a full reset pulse can still catch the op running
    parameter int unsigned OP_BUSY_CYC = 4096
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    sfr_link_if.dev link,
    input wire logic supply_ok_i,
    output logic standby_o,
    output logic write_enable_latch_o,
    output logic write_in_progress_o,
    output logic addr4_o,
    output logic lock_o,
    output logic in_reset_o,
    output logic op_aborted_o
);
    typedef struct packed {
        sfr_pkg::sfr_dev_state_type st;
        logic [11:0] rst_cnt;
        logic full_rst;
        logic sclk_q;
        logic [2:0] bit_cnt;
        logic [7:0] sh;
        logic [7:0] out_sh;
        logic out_en;
        logic so;
        logic write_enable_latch;
        logic write_in_progress;
        logic lock;
        logic addr4;
        logic aborted;
        logic [27:0] busy_cnt;
    } sfr_dev_regs_type;
    sfr_dev_regs_type r_r;
    sfr_dev_regs_type r_nxt;
    logic [4:0] s;
    logic [7:0] cmd;
    logic [7:0] stat;
    sfr_sync #(.W(5)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({supply_ok_i, link.reset_n, link.cs_n, link.sclk, link.si}),
        .q_o(s)
    );
    always_comb begin
        stat = 8'h00;
        stat[`SFR_ST_WRITE_IN_PROGRESS] = r_r.write_in_progress;
        stat[`SFR_ST_WRITE_ENABLE_LATCH] = r_r.write_enable_latch;
        stat[`SFR_ST_ADDR4] = r_r.addr4;
        stat[`SFR_ST_LOCK] = r_r.lock;
        cmd = {r_r.sh[6:0], s[0]};
        r_nxt = r_r;
        r_nxt.sclk_q = s[1];
        if (r_r.write_in_progress) begin
            if (r_r.busy_cnt == 28'h0) begin
                r_nxt.write_in_progress = 1'b0;
            end else begin
                r_nxt.busy_cnt = r_r.busy_cnt - 28'h1;
            end
        end
        case (r_r.st)
            sfr_pkg::DEV_POR: begin
                // wakes into standby, never deep power-down, latch clear
                r_nxt.st = sfr_pkg::DEV_STANDBY; // [R8]
            end
            sfr_pkg::DEV_STANDBY: begin
                if (!s[3]) begin
                    r_nxt.st = sfr_pkg::DEV_RESET;
                    // this cycle is already the first low sample of the pulse
                    r_nxt.rst_cnt = 12'h1; // [R1]
                    r_nxt.out_en = 1'b0; // [R4]
                    r_nxt.bit_cnt = 3'h0;
                end else if (s[2]) begin
                    r_nxt.bit_cnt = 3'h0;
                    r_nxt.out_en = 1'b0;
                end else if (s[1] && !r_r.sclk_q && !r_r.out_en) begin
                    r_nxt.sh = cmd;
                    r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
                    if (r_r.bit_cnt == 3'h7) begin
                        if (cmd == `SFR_CMD_READ_STATUS) begin
                            r_nxt.out_en = 1'b1;
                            r_nxt.out_sh = stat;
                        end else if (!r_r.write_in_progress) begin
                            case (cmd)
                                `SFR_CMD_WRITE_ENABLE: r_nxt.write_enable_latch = 1'b1;
                                `SFR_CMD_WRITE_DISABLE: r_nxt.write_enable_latch = 1'b0;
                                `SFR_CMD_ENTER_ADDR4: r_nxt.addr4 = 1'b1;
                                `SFR_CMD_EXIT_ADDR4: r_nxt.addr4 = 1'b0;
                                `SFR_CMD_LOCK_ALL: r_nxt.lock = 1'b1;
                                `SFR_CMD_UNLOCK_ALL: r_nxt.lock = 1'b0;
                                `SFR_CMD_PROGRAM, `SFR_CMD_SMALL_SECTOR_ERASE,
                                `SFR_CMD_BLOCK_ERASE, `SFR_CMD_CHIP_ERASE,
                                `SFR_CMD_STATUS_WRITE: begin
                                    if (r_r.write_enable_latch) begin
                                        r_nxt.write_in_progress = 1'b1;
                                        r_nxt.write_enable_latch = 1'b0;
                                        r_nxt.aborted = 1'b0;
                                        r_nxt.busy_cnt = 28'(OP_BUSY_CYC);
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end else if (!s[1] && r_r.sclk_q && r_r.out_en) begin
                    r_nxt.so = r_r.out_sh[7];
                    r_nxt.out_sh = {r_r.out_sh[6:0], 1'b0};
                end
            end
            sfr_pkg::DEV_RESET: begin
                // pin low: output released, decode frozen
                r_nxt.out_en = 1'b0; // [R4]
                r_nxt.bit_cnt = 3'h0;
                if (s[3]) begin
                    // a pulse shorter than the minimum leaves state untouched
                    r_nxt.st = sfr_pkg::DEV_STANDBY;
                    r_nxt.full_rst = 1'b0;
                end else if (r_r.rst_cnt != 12'(`SFR_RESET_PULSE_CYC - 1)) begin
                    r_nxt.rst_cnt = r_r.rst_cnt + 12'h1;
                end else if (!r_r.full_rst) begin
                    r_nxt.full_rst = 1'b1; // [R1]
                    r_nxt.aborted = r_r.write_in_progress; // [R3]
                    r_nxt.write_in_progress = 1'b0; // [R3]
                    r_nxt.busy_cnt = 28'h0;
                    r_nxt.write_enable_latch = 1'b0; // [R2]
                    r_nxt.lock = 1'b0; // [R2]
                    r_nxt.addr4 = 1'b0; // [R2]
                end
            end
            default: begin
                r_nxt.st = sfr_pkg::DEV_POR;
            end
        endcase
        if (!s[4]) begin
            // below the inhibit threshold everything is held cleared
            r_nxt = '0; // [R9]
            r_nxt.st = sfr_pkg::DEV_POR; // [R9]
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
    assign link.so = r_r.so;
    assign link.so_oe = r_r.out_en & ~s[2] & (r_r.st == sfr_pkg::DEV_STANDBY); // [R4]
    assign standby_o = (r_r.st == sfr_pkg::DEV_STANDBY) & ~r_r.write_in_progress; // [R2]
    assign write_enable_latch_o = r_r.write_enable_latch;
    assign write_in_progress_o = r_r.write_in_progress;
    assign addr4_o = r_r.addr4;
    assign lock_o = r_r.lock;
    assign in_reset_o = (r_r.st == sfr_pkg::DEV_RESET);
    assign op_aborted_o = r_r.aborted;
endmodule // sfr_flash_dev
`default_nettype wire

// ### hdl/sfr_flash_host.sv
// flash controller end: power-up wait, reset pulse, recovery and command shift
//
// Overview of operation
// R1: reset pin held low at least 10 us
// R2: after reset: standby, volatile bits cleared, 3-byte
// R3: reset aborts running program or erase
// R4: data output released during reset cycle
// R5: wait 10 us after reset release before select
// R6: decode or read interrupted: 40 us recovery
// R7: interrupted operation: wait its own recovery time
// R8: power-up into standby with write latch clear
// R9: below inhibit threshold device ignores all commands
// R10: commands only after supply valid plus settle
// R11: keep deselected until supply valid and settled
// R12: waits derived from clock, counts rounded up
`include "sfr_cfg.svh"
`default_nettype none
module sfr_flash_host #(
    parameter int unsigned SUPPLY_SETTLE_CYC = 1000,
    parameter int unsigned REC_DECODE_CYC = `SFR_US2CYC(`SFR_RECOVERY_DECODE_US),
    parameter int unsigned REC_READ_CYC = `SFR_US2CYC(`SFR_RECOVERY_READ_US),
    parameter int unsigned REC_PROGRAM_CYC = `SFR_US2CYC(`SFR_RECOVERY_PROGRAM_US),
    parameter int unsigned REC_SMALL_CYC = `SFR_MS2CYC(`SFR_RECOVERY_SMALL_ERASE_MS),
    parameter int unsigned REC_BLOCK_CYC = `SFR_MS2CYC(`SFR_RECOVERY_BLOCK_ERASE_MS),
    parameter int unsigned REC_CHIP_CYC = `SFR_MS2CYC(`SFR_RECOVERY_CHIP_ERASE_MS),
    parameter int unsigned REC_STATUS_CYC = `SFR_MS2CYC(`SFR_RECOVERY_STATUS_WRITE_MS)
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    sfr_link_if.host link,
    input wire logic supply_valid_i,
    input wire logic reset_req_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_i,
    output logic cmd_ready_o,
    output logic ready_o,
    output logic resetting_o,
    output logic [7:0] status_o,
    output logic status_valid_o
);
    typedef struct packed {
        sfr_pkg::sfr_host_state_type st;
        logic [27:0] cnt;
        logic [3:0] div;
        logic [3:0] bit_cnt;
        logic is_read;
        logic [7:0] sh;
        logic [7:0] rx;
        logic cs_n;
        logic sclk;
        logic si;
        logic rst_n;
        sfr_pkg::sfr_op_type pending;
        sfr_pkg::sfr_op_type rec_sel;
        logic [7:0] status;
        logic stat_v;
    } sfr_host_regs_type;
    localparam sfr_host_regs_type RESET_VAL = '{
        st: sfr_pkg::H_POWERUP,
        cnt: 28'h0,
        div: 4'h0,
        bit_cnt: 4'h0,
        is_read: 1'b0,
        sh: 8'h00,
        rx: 8'h00,
        cs_n: 1'b1,
        sclk: 1'b0,
        si: 1'b0,
        rst_n: 1'b1,
        pending: sfr_pkg::OP_NONE,
        rec_sel: sfr_pkg::OP_NONE,
        status: 8'h00,
        stat_v: 1'b0
    };
    sfr_host_regs_type r_r;
    sfr_host_regs_type r_nxt;
    logic [1:0] s;
    logic [7:0] rx_full;
    logic [27:0] rec_last;
    sfr_sync #(.W(2)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({supply_valid_i, link.so_line}),
        .q_o(s)
    );
    // recovery count, last cycle index; the select delay is the floor
    function automatic logic [27:0] rec_cycles(input sfr_pkg::sfr_op_type k);
        logic [27:0] c;
        case (k)
            sfr_pkg::OP_DECODE: c = 28'(REC_DECODE_CYC); // [R6]
            sfr_pkg::OP_READ: c = 28'(REC_READ_CYC); // [R6]
            sfr_pkg::OP_PROGRAM: c = 28'(REC_PROGRAM_CYC); // [R7]
            sfr_pkg::OP_SMALL_ERASE: c = 28'(REC_SMALL_CYC); // [R7]
            sfr_pkg::OP_BLOCK_ERASE: c = 28'(REC_BLOCK_CYC); // [R7]
            sfr_pkg::OP_CHIP_ERASE: c = 28'(REC_CHIP_CYC); // [R7]
            sfr_pkg::OP_STATUS_WRITE: c = 28'(REC_STATUS_CYC); // [R7]
            default: c = 28'(`SFR_RESET_TO_SELECT_CYC); // [R5]
        endcase
        if (c < 28'(`SFR_RESET_TO_SELECT_CYC)) begin
            c = 28'(`SFR_RESET_TO_SELECT_CYC); // [R5]
        end
        return c - 28'h1;
    endfunction
    // opcode to the long operation it starts, if any
    function automatic sfr_pkg::sfr_op_type op_of(input logic [7:0] c);
        case (c)
            `SFR_CMD_PROGRAM: op_of = sfr_pkg::OP_PROGRAM;
            `SFR_CMD_SMALL_SECTOR_ERASE: op_of = sfr_pkg::OP_SMALL_ERASE;
            `SFR_CMD_BLOCK_ERASE: op_of = sfr_pkg::OP_BLOCK_ERASE;
            `SFR_CMD_CHIP_ERASE: op_of = sfr_pkg::OP_CHIP_ERASE;
            `SFR_CMD_STATUS_WRITE: op_of = sfr_pkg::OP_STATUS_WRITE;
            default: op_of = sfr_pkg::OP_NONE;
        endcase
    endfunction
    assign rx_full = {r_r.rx[6:0], s[0]};
    assign rec_last = rec_cycles(r_r.rec_sel);
    always_comb begin
        r_nxt = r_r;
        r_nxt.stat_v = 1'b0;
        case (r_r.st)
            sfr_pkg::H_POWERUP: begin
                r_nxt.cs_n = 1'b1; // [R11]
                r_nxt.sclk = 1'b0;
                r_nxt.rst_n = 1'b1;
                if (!s[1]) begin
                    r_nxt.cnt = 28'h0; // [R10]
                end else if (r_r.cnt == 28'(SUPPLY_SETTLE_CYC - 1)) begin
                    r_nxt.st = sfr_pkg::H_IDLE; // [R10]
                    r_nxt.cnt = 28'h0;
                end else begin
                    r_nxt.cnt = r_r.cnt + 28'h1;
                end
            end
            sfr_pkg::H_IDLE: begin
                if (reset_req_i) begin
                    r_nxt.st = sfr_pkg::H_RST_LOW;
                    r_nxt.rst_n = 1'b0;
                    r_nxt.cnt = 28'h0;
                    r_nxt.rec_sel = r_r.pending; // [R7]
                end else if (cmd_valid_i) begin
                    r_nxt.st = sfr_pkg::H_SHIFT;
                    r_nxt.cs_n = 1'b0;
                    r_nxt.sh = cmd_i;
                    r_nxt.si = cmd_i[7];
                    r_nxt.div = 4'h0;
                    r_nxt.bit_cnt = 4'h0;
                    r_nxt.is_read = (cmd_i == `SFR_CMD_READ_STATUS);
                    if (op_of(cmd_i) != sfr_pkg::OP_NONE) begin
                        r_nxt.pending = op_of(cmd_i);
                    end
                end
            end
            sfr_pkg::H_SHIFT: begin
                if (reset_req_i) begin
                    // reset cuts the transfer short; recovery covers the decode
                    r_nxt.st = sfr_pkg::H_RST_LOW;
                    r_nxt.rst_n = 1'b0;
                    r_nxt.cs_n = 1'b1;
                    r_nxt.sclk = 1'b0;
                    r_nxt.cnt = 28'h0;
                    if (r_r.pending != sfr_pkg::OP_NONE) begin
                        r_nxt.rec_sel = r_r.pending; // [R7]
                    end else if (r_r.is_read) begin
                        r_nxt.rec_sel = sfr_pkg::OP_READ; // [R6]
                    end else begin
                        r_nxt.rec_sel = sfr_pkg::OP_DECODE; // [R6]
                    end
                end else begin
                    r_nxt.div = r_r.div + 4'h1;
                    if (r_r.div == `SFR_SCLK_HALF - 4'h1) begin
                        r_nxt.sclk = 1'b1;
                    end
                    if (r_r.div == 4'hf) begin
                        // sample late in the high phase to cover both synchronisers
                        r_nxt.sclk = 1'b0;
                        r_nxt.rx = rx_full;
                        r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
                        r_nxt.sh = {r_r.sh[6:0], 1'b0};
                        r_nxt.si = r_r.sh[6];
                        if (r_r.bit_cnt == (r_r.is_read ? 4'hf : 4'h7)) begin
                            r_nxt.st = sfr_pkg::H_IDLE;
                            r_nxt.cs_n = 1'b1;
                            if (r_r.is_read) begin
                                r_nxt.status = rx_full;
                                r_nxt.stat_v = 1'b1;
                                if (!rx_full[`SFR_ST_WRITE_IN_PROGRESS]) begin
                                    r_nxt.pending = sfr_pkg::OP_NONE;
                                end
                            end
                        end
                    end
                end
            end
            sfr_pkg::H_RST_LOW: begin
                r_nxt.cs_n = 1'b1;
                if (r_r.cnt == 28'(`SFR_RESET_PULSE_CYC - 1)) begin
                    r_nxt.rst_n = 1'b1; // [R1] [R12]
                    r_nxt.st = sfr_pkg::H_RECOVER;
                    r_nxt.cnt = 28'h0;
                end else begin
                    r_nxt.cnt = r_r.cnt + 28'h1;
                end
            end
            sfr_pkg::H_RECOVER: begin
                // select stays high for the full recovery, never shortened
                r_nxt.cs_n = 1'b1; // [R5]
                if (r_r.cnt == rec_last) begin
                    r_nxt.st = sfr_pkg::H_IDLE; // [R6] [R7]
                    r_nxt.pending = sfr_pkg::OP_NONE;
                    r_nxt.cnt = 28'h0;
                end else begin
                    r_nxt.cnt = r_r.cnt + 28'h1;
                end
            end
            default: begin
                r_nxt = RESET_VAL;
            end
        endcase
        if (!s[1] && r_r.st != sfr_pkg::H_POWERUP) begin
            // supply lost: drop back and hold the device deselected
            r_nxt = RESET_VAL; // [R11]
        end
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_r <= RESET_VAL;
        end else begin
            r_r <= r_nxt;
        end
    end
    assign link.reset_n = r_r.rst_n;
    assign link.cs_n = r_r.cs_n;
    assign link.sclk = r_r.sclk;
    assign link.si = r_r.si;
    assign cmd_ready_o = (r_r.st == sfr_pkg::H_IDLE) & ~reset_req_i & s[1];
    assign ready_o = (r_r.st == sfr_pkg::H_IDLE);
    assign resetting_o = (r_r.st == sfr_pkg::H_RST_LOW) | (r_r.st == sfr_pkg::H_RECOVER);
    assign status_o = r_r.status;
    assign status_valid_o = r_r.stat_v;
endmodule // sfr_flash_host
`default_nettype wire

// ### hdl/sfr_link_if.sv
// link pins between flash controller and flash device
`default_nettype none
interface sfr_link_if;
    logic reset_n;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;
    // released output floats high through the board pull-up
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input reset_n, input cs_n, input sclk, input si, output so, output so_oe);
    modport host (output reset_n, output cs_n, output sclk, output si, input so_line);
endinterface
`default_nettype wire

// ### hdl/sfr_pkg.sv
// types shared by both ends of the serial flash reset link
`default_nettype none
package sfr_pkg;
    typedef enum logic [1:0] {
        DEV_POR = 2'h0,
        DEV_STANDBY = 2'h1,
        DEV_RESET = 2'h2
    } sfr_dev_state_type;
    typedef enum logic [2:0] {
        H_POWERUP = 3'h0,
        H_IDLE = 3'h1,
        H_SHIFT = 3'h2,
        H_RST_LOW = 3'h3,
        H_RECOVER = 3'h4
    } sfr_host_state_type;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_DECODE = 3'h1,
        OP_READ = 3'h2,
        OP_PROGRAM = 3'h3,
        OP_SMALL_ERASE = 3'h4,
        OP_BLOCK_ERASE = 3'h5,
        OP_CHIP_ERASE = 3'h6,
        OP_STATUS_WRITE = 3'h7
    } sfr_op_type;
endpackage
`default_nettype wire

// ### hdl/sfr_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module sfr_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sfr_sync_regs_type;
    sfr_sync_regs_type r_r;
    sfr_sync_regs_type r_nxt;
    always_comb begin
        r_nxt.meta = d_i;
        r_nxt.sync = r_r.meta;
    end
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
    assign q_o = r_r.sync;
endmodule // sfr_sync
`default_nettype wire
